// ===== pa_cpu_model.sv
// Purpose: Four-bit CPU bus partner running a short program loop
// Assumes: One CPU phase every second pclk
// Notes:   Address 2 holds a port-select instruction
`timescale 1ns/100ps
`default_nettype none
module pa_cpu_model #(
    parameter int LOOP = 5
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        target_reset,
    output logic             phase_en,
    output logic             cpu_sync,
    output logic      [3:0]  cpu_data,
    output logic      [3:0]  ram_bank_select_lines,
    output logic             cyc_end,
    output logic      [11:0] cyc_addr
);
    logic        div_r;
    logic [2:0]  ph_r;
    logic [11:0] pc_r;
    logic [7:0]  op;
    logic [7:0]  ex;
    // ========================================================
    // Sequencer: reset keeps cycles running but pins the pc at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 1'b0;
            ph_r  <= 3'h0;
            pc_r  <= 12'h000;
        end else begin
            div_r <= ~div_r;
            if (div_r) begin
                ph_r <= ph_r + 3'h1;
                if (ph_r == 3'h7) begin
                    pc_r <= (target_reset || pc_r == 12'(LOOP - 1)) ?
                            12'h000 : pc_r + 12'h001;
                end
            end
        end
    end
    // ========================================================
    // Bus nibbles; X1 carries a toggling pattern, not a stale value
    always_comb begin
        op = (pc_r == 12'h002) ? 8'h21 : {4'hD, pc_r[3:0]};
        ex = {pc_r[3:0], ~pc_r[3:0]};
        case (ph_r)
            3'h0: cpu_data = pc_r[3:0];
            3'h1: cpu_data = pc_r[7:4];
            3'h2: cpu_data = pc_r[11:8];
            3'h3: cpu_data = op[7:4];
            3'h4: cpu_data = op[3:0];
            3'h5: cpu_data = {div_r, ~div_r, div_r, ~div_r};
            3'h6: cpu_data = ex[7:4];
            default: cpu_data = ex[3:0];
        endcase
    end
    assign phase_en = div_r;
    assign cpu_sync = (ph_r == 3'h7);
    assign ram_bank_select_lines = 4'h1 << pc_r[1:0];
    assign cyc_end = div_r && (ph_r == 3'h7);
    assign cyc_addr = pc_r;
endmodule
`default_nettype wire

// ===== pa_cyc_if.sv
// Purpose: Carries per-cycle capture from the bus sampler to the top
// Assumes: One producer, one consumer on pclk
// Notes:   cyc_done pulses once per instruction cycle
`timescale 1ns/100ps
`default_nettype none
interface pa_cyc_if;
    logic        cyc_done;
    logic [11:0] addr;
    logic [7:0]  instr;
    logic [7:0]  exec;
    logic [3:0]  bank;
    logic [7:0]  x2x3;

    modport src (output cyc_done, addr, instr, exec, bank, x2x3);
    modport dst (input  cyc_done, addr, instr, exec, bank, x2x3);
endinterface
`default_nettype wire

// ===== pa_pkg.sv
// Purpose: Shared constants and types for the bus program analyzer
// Assumes: Four-bit CPU, eight clock phases per instruction cycle
// Notes:   APB register map and field positions live here
package pa_pkg;

    // ========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_SETUP     = 8'h04;
    localparam logic [7:0] ADDR_CMD       = 8'h08;
    localparam logic [7:0] ADDR_CAPTURE   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS    = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;
    localparam logic [7:0] ADDR_TRIG_NOW  = 8'h1C;

    // ========================================================
    // Control register fields
    localparam int CTRL_STEP_PAST = 0;
    localparam int CTRL_RUN_MODE  = 1;
    localparam int CTRL_TEST_HOLD = 2;

    // Setup register fields
    localparam int SETUP_ADDR_LSB = 0;
    localparam int SETUP_PASS_LSB = 12;

    // Command register bits (write one to act)
    localparam int CMD_LOAD       = 0;
    localparam int CMD_INC        = 1;
    localparam int CMD_DEC        = 2;
    localparam int CMD_TEST_PULSE = 3;
    localparam int CMD_RESET      = 4;

    // Interrupt status bits
    localparam int IRQ_COMPLETE = 0;
    localparam int IRQ_POINTER  = 1;
    localparam int IRQ_RUN_SYNC = 2;
    localparam int IRQ_W        = 3;

    // ========================================================
    // Timing and widths
    localparam logic [2:0] PH_A1      = 3'h0;
    localparam logic [2:0] PH_A2      = 3'h1;
    localparam logic [2:0] PH_A3      = 3'h2;
    localparam logic [2:0] PH_M1      = 3'h3;
    localparam logic [2:0] PH_M2      = 3'h4;
    localparam logic [2:0] PH_X1      = 3'h5;
    localparam logic [2:0] PH_X2      = 3'h6;
    localparam logic [2:0] PH_X3      = 3'h7;
    localparam logic [1:0] TEST_CYCLES   = 2'h2;
    localparam logic [3:0] PASS_MIN      = 4'h1;
    localparam logic [3:0] PORT_SEL_OPC  = 4'h2;
    localparam logic [3:0] RESET_CYCLES  = 4'h8;

    typedef enum logic [1:0] {
        PA_ARMED,
        PA_STEP,
        PA_DONE
    } pa_trig_e;

endpackage

// ===== pa_sampler.sv
// Purpose: Assembles the nibbles of one instruction cycle
// Assumes: Bus and sync sampled once per phase_en pulse
// Notes:   Sync marks the last phase, X3, of the cycle
`timescale 1ns/100ps
`default_nettype none
module pa_sampler (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       phase_en,
    input  wire logic       cpu_sync,
    input  wire logic [3:0] cpu_data,
    input  wire logic [3:0] ram_bank_select_lines,
    pa_cyc_if.src           cyc
);
    logic [2:0]  phase_r;
    logic [11:0] addr_r;
    logic [7:0]  instr_r;
    logic [7:0]  exec_r;
    logic [3:0]  bank_r;
    logic        done_r;

    // ========================================================
    // Phase counter, realigned by sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= pa_pkg::PH_A1;
        end else if (phase_en) begin
            phase_r <= cpu_sync ? pa_pkg::PH_A1 : phase_r + 3'h1;
        end
    end

    // ========================================================
    // Nibble capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r  <= '0;
            instr_r <= '0;
            exec_r  <= '0;
            bank_r  <= '0;
        end else if (phase_en) begin
            case (phase_r)
                pa_pkg::PH_A1: addr_r[3:0]   <= cpu_data;
                pa_pkg::PH_A2: addr_r[7:4]   <= cpu_data;
                pa_pkg::PH_A3: addr_r[11:8]  <= cpu_data;
                pa_pkg::PH_M1: instr_r[7:4]  <= cpu_data;
                pa_pkg::PH_M2: instr_r[3:0]  <= cpu_data;
                pa_pkg::PH_X2: exec_r[7:4]   <= cpu_data;
                pa_pkg::PH_X3: exec_r[3:0]   <= cpu_data;
                default:       bank_r        <= bank_r;
            endcase
            if (ram_bank_select_lines != 4'h0) begin
                bank_r <= ram_bank_select_lines;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= phase_en && (phase_r == pa_pkg::PH_X3);
        end
    end

    assign cyc.cyc_done = done_r;
    assign cyc.addr     = addr_r;
    assign cyc.instr    = instr_r;
    assign cyc.exec     = exec_r;
    assign cyc.bank     = bank_r;
    assign cyc.x2x3     = exec_r;
endmodule
`default_nettype wire

// ===== pa_top.sv
// Purpose: Real-time program analyzer on a four-bit CPU data bus
// Assumes: phase_en marks each CPU clock phase; APB on pclk
// Notes:   Trigger, pass counter, pointer latch, test line drive
`timescale 1ns/100ps
`default_nettype none

module pa_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        phase_en,
    input  wire logic        cpu_sync,
    input  wire logic [3:0]  cpu_data,
    input  wire logic [3:0]  ram_bank_select_lines,
    output logic             cpu_test,
    output logic             target_reset,
    output logic             run_sync_pulse,
    output logic             trigger_complete,
    output logic             pointer_valid,
    output logic      [11:0] ext_addr,
    output logic      [7:0]  ext_instr,
    output logic      [7:0]  ext_exec,
    output logic      [3:0]  ext_bank,
    output logic      [7:0]  ext_pointer,
    output logic             irq
);
    pa_cyc_if cyc ();

    pa_sampler u_sampler (
        .pclk                  (pclk),
        .presetn               (presetn),
        .phase_en              (phase_en),
        .cpu_sync              (cpu_sync),
        .cpu_data              (cpu_data),
        .ram_bank_select_lines (ram_bank_select_lines),
        .cyc                   (cyc)
    );

    pa_pkg::pa_trig_e state_r;
    logic [2:0]  ctrl_r;
    logic [15:0] setup_r;
    logic [11:0] trig_addr_r;
    logic [3:0]  pass_left_r;
    logic [11:0] cap_addr_r;
    logic [7:0]  cap_instr_r;
    logic [7:0]  cap_exec_r;
    logic [3:0]  cap_bank_r;
    logic [7:0]  pointer_r;
    logic        ptr_valid_r;
    logic        run_sync_r;
    logic [1:0]  test_cnt_r;
    logic [3:0]  rst_cnt_r;
    logic [pa_pkg::IRQ_W-1:0] irq_stat_r;
    logic [pa_pkg::IRQ_W-1:0] irq_mask_r;
    logic [31:0] prdata_r;

    logic wr_en;
    logic rd_en;
    logic cmd_wr;
    logic do_load;
    logic do_inc;
    logic do_dec;
    logic do_test;
    logic do_reset;
    logic match;
    logic port_sel;
    logic frozen;
    logic complete_ev;
    logic run_ev;
    logic [pa_pkg::IRQ_W-1:0] ev_vec;

    // ========================================================
    // APB decode, zero wait states
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign cmd_wr  = wr_en && (paddr == pa_pkg::ADDR_CMD);

    assign do_load  = cmd_wr && pwdata[pa_pkg::CMD_LOAD];
    assign do_inc   = cmd_wr && pwdata[pa_pkg::CMD_INC];
    assign do_dec   = cmd_wr && pwdata[pa_pkg::CMD_DEC];
    assign do_test  = cmd_wr && pwdata[pa_pkg::CMD_TEST_PULSE];
    assign do_reset = cmd_wr && pwdata[pa_pkg::CMD_RESET];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= '0;
            setup_r <= {pa_pkg::PASS_MIN, 12'h000};
        end else if (wr_en && paddr == pa_pkg::ADDR_CTRL) begin
            ctrl_r <= pwdata[2:0];
        end else if (wr_en && paddr == pa_pkg::ADDR_SETUP) begin
            setup_r <= pwdata[15:0];
        end
    end

    // ========================================================
    // Trigger comparison
    assign frozen   = (state_r == pa_pkg::PA_DONE);
    assign match    = cyc.cyc_done && (cyc.addr == trig_addr_r);
    assign port_sel = cyc.cyc_done &&
                      (cyc.instr[7:4] == pa_pkg::PORT_SEL_OPC) &&
                      cyc.instr[0];
    // Silent while still frozen, until a command re-arms
    assign run_ev   = match && ctrl_r[pa_pkg::CTRL_RUN_MODE] &&
                      !frozen;
    assign complete_ev = cyc.cyc_done && !ctrl_r[pa_pkg::CTRL_RUN_MODE] &&
        (((state_r == pa_pkg::PA_ARMED) && match &&
          (pass_left_r <= pa_pkg::PASS_MIN) &&
          !ctrl_r[pa_pkg::CTRL_STEP_PAST]) ||
         (state_r == pa_pkg::PA_STEP));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_addr_r <= '0;
        end else if (do_load) begin
            trig_addr_r <= setup_r[pa_pkg::SETUP_ADDR_LSB +: 12];
        end else if (do_inc) begin
            trig_addr_r <= trig_addr_r + 12'h001;
        end else if (do_dec) begin
            trig_addr_r <= trig_addr_r - 12'h001;
        end
    end

    // Trigger state; a load, increment, decrement or reset command re-arms, a test pulse does not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= pa_pkg::PA_ARMED;
            pass_left_r <= pa_pkg::PASS_MIN;
        end else if (do_load || do_inc || do_dec || do_reset) begin
            state_r     <= pa_pkg::PA_ARMED;
            pass_left_r <= do_load ?
                setup_r[pa_pkg::SETUP_PASS_LSB +: 4] : pass_left_r;
        end else begin
            case (state_r)
                pa_pkg::PA_ARMED: begin
                    if (match && !ctrl_r[pa_pkg::CTRL_RUN_MODE]) begin
                        if (pass_left_r > pa_pkg::PASS_MIN) begin
                            pass_left_r <= pass_left_r - 4'h1;
                        end else if (ctrl_r[pa_pkg::CTRL_STEP_PAST]) begin
                            state_r <= pa_pkg::PA_STEP;
                        end else begin
                            state_r <= pa_pkg::PA_DONE;
                        end
                    end
                end
                pa_pkg::PA_STEP: begin
                    if (cyc.cyc_done) begin
                        state_r <= pa_pkg::PA_DONE;
                    end
                end
                pa_pkg::PA_DONE: state_r <= pa_pkg::PA_DONE;
                default:         state_r <= pa_pkg::PA_ARMED;
            endcase
        end
    end

    // ========================================================
    // Captured display values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_addr_r  <= '0;
            cap_instr_r <= '0;
            cap_exec_r  <= '0;
            cap_bank_r  <= '0;
        end else if (cyc.cyc_done && !frozen) begin
            cap_addr_r  <= cyc.addr;
            cap_instr_r <= cyc.instr;
            cap_exec_r  <= cyc.exec;
            cap_bank_r  <= cyc.bank;
        end
    end

    // Pointer latch; the X2/X3 pair carries the register pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pointer_r   <= '0;
            ptr_valid_r <= 1'b0;
        end else if (port_sel && !frozen) begin
            pointer_r   <= cyc.x2x3;
            ptr_valid_r <= 1'b1;
        end else if (do_reset) begin
            // New pointer beats a reset command
            ptr_valid_r <= 1'b0;
        end
    end

    // ========================================================
    // Test line, target reset, run sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_cnt_r <= '0;
        end else if (do_test) begin
            test_cnt_r <= pa_pkg::TEST_CYCLES;
        end else if (cyc.cyc_done && test_cnt_r != 2'h0) begin
            test_cnt_r <= test_cnt_r - 2'h1;
        end
    end

    // Counted in instruction cycles so a halted CPU keeps it high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_r <= '0;
        end else if (do_reset) begin
            rst_cnt_r <= pa_pkg::RESET_CYCLES;
        end else if (cyc.cyc_done && rst_cnt_r != 4'h0) begin
            rst_cnt_r <= rst_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_sync_r <= 1'b0;
        end else begin
            run_sync_r <= run_ev;
        end
    end

    // ========================================================
    // Interrupt status, cleared by read; set wins
    assign ev_vec = {run_ev, port_sel && !frozen, complete_ev};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
        end else if (rd_en && paddr == pa_pkg::ADDR_IRQ_STAT) begin
            // Only bits reported at setup are cleared
            irq_stat_r <= (irq_stat_r & ~prdata[pa_pkg::IRQ_W-1:0]) |
                          ev_vec;
        end else begin
            irq_stat_r <= irq_stat_r | ev_vec;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= '0;
        end else if (wr_en && paddr == pa_pkg::ADDR_IRQ_MASK) begin
            irq_mask_r <= pwdata[pa_pkg::IRQ_W-1:0];
        end
    end

    // ========================================================
    // Read mux
    always_comb begin
        prdata_r = 32'h0000_0000;
        case (paddr)
            pa_pkg::ADDR_CTRL:     prdata_r[2:0]  = ctrl_r;
            pa_pkg::ADDR_SETUP:    prdata_r[15:0] = setup_r;
            pa_pkg::ADDR_CAPTURE:  prdata_r = {cap_bank_r, cap_exec_r,
                                              cap_instr_r, cap_addr_r};
            pa_pkg::ADDR_STATUS:   prdata_r[15:0] = {pointer_r,
                                       pass_left_r, 1'b0,
                                       ptr_valid_r, frozen,
                                       test_cnt_r != 2'h0};
            pa_pkg::ADDR_IRQ_STAT: prdata_r[pa_pkg::IRQ_W-1:0] = irq_stat_r;
            pa_pkg::ADDR_IRQ_MASK: prdata_r[pa_pkg::IRQ_W-1:0] = irq_mask_r;
            pa_pkg::ADDR_TRIG_NOW: prdata_r[11:0] = trig_addr_r;
            default:               prdata_r = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= prdata_r;
        end
    end

    // ========================================================
    // External buffered outputs
    assign cpu_test = (test_cnt_r != 2'h0) ||
                      ctrl_r[pa_pkg::CTRL_TEST_HOLD];
    assign target_reset     = (rst_cnt_r != 4'h0);
    assign run_sync_pulse   = run_sync_r;
    assign trigger_complete = frozen;
    assign pointer_valid    = ptr_valid_r;
    assign ext_addr    = cap_addr_r;
    assign ext_instr   = cap_instr_r;
    assign ext_exec    = cap_exec_r;
    assign ext_bank    = cap_bank_r;
    assign ext_pointer = pointer_r;
    assign irq = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

// ===== pa_top_assertions.sv
// Purpose: Port-level checks of the bus program analyzer
// Assumes: Only the top-level ports are visible
// Notes:   Bound into every pa_top instance
`timescale 1ns/100ps
`default_nettype none
module pa_top_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        phase_en,
    input wire logic        cpu_sync,
    input wire logic        target_reset,
    input wire logic        run_sync_pulse,
    input wire logic        trigger_complete,
    input wire logic [11:0] ext_addr,
    input wire logic [7:0]  ext_instr,
    input wire logic [7:0]  ext_exec,
    input wire logic [3:0]  ext_bank,
    input wire logic [7:0]  ext_pointer
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================================
    // Helpers
    logic       x3;
    logic [3:0] rst_cyc_r;
    assign x3 = phase_en && cpu_sync;
    // Saturates so a stuck reset cannot wrap into the legal band
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cyc_r <= 4'h0;
        end else if (!target_reset) begin
            rst_cyc_r <= 4'h0;
        end else if (x3 && rst_cyc_r != 4'hF) begin
            rst_cyc_r <= rst_cyc_r + 4'h1;
        end
    end
    // ========================================================
    // Properties
    capture_cadence_a: assert property (
        $changed(ext_addr) && !$past(psel) |-> $past(x3, 2))
        else $error("capture moved away from a cycle end");
    frozen_hold_a: assert property (
        trigger_complete && $past(trigger_complete) |-> $stable(ext_addr)
        && $stable(ext_instr) && $stable(ext_exec) && $stable(ext_bank))
        else $error("frozen capture changed");
    pointer_hold_a: assert property (
        trigger_complete && $past(trigger_complete) |-> $stable(ext_pointer))
        else $error("pointer changed after completion");
    run_pulse_a: assert property (
        run_sync_pulse |=> !run_sync_pulse)
        else $error("run sync wider than one clock");
    run_cadence_a: assert property (
        run_sync_pulse |-> $past(x3) || $past(x3, 2))
        else $error("run sync not at a cycle end");
    run_nofreeze_a: assert property (
        run_sync_pulse |-> !trigger_complete)
        else $error("run sync while frozen");
    trig_cadence_a: assert property (
        $rose(trigger_complete) |-> $past(x3) || $past(x3, 2))
        else $error("completion not at a cycle end");
    treset_hold_a: assert property (
        $rose(target_reset) |=> target_reset [*8])
        else $error("target reset too short");
    treset_len_a: assert property (
        $fell(target_reset) |-> rst_cyc_r >= 4'h7 && rst_cyc_r <= 4'h9)
        else $error("target reset not eight cycles");
    cover property ($rose(trigger_complete));
    cover property (run_sync_pulse);
    cover property ($rose(target_reset));
endmodule
bind pa_top pa_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .phase_en(phase_en), .cpu_sync(cpu_sync), .target_reset(target_reset),
    .run_sync_pulse(run_sync_pulse), .trigger_complete(trigger_complete),
    .ext_addr(ext_addr), .ext_instr(ext_instr), .ext_exec(ext_exec),
    .ext_bank(ext_bank), .ext_pointer(ext_pointer));
`default_nettype wire

// ===== pa_top_tb.sv
// Purpose: Self-checking bench for the bus program analyzer
// Assumes: Partner loops addresses 0 to 4
// Notes:   Registers reached only through APB tasks
`timescale 1ns/100ps
`default_nettype none
module pa_top_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, ext_instr, ext_exec, ext_pointer;
    logic [31:0] pwdata, prdata, rv;
    logic        phase_en, cpu_sync, cpu_test, target_reset, irq;
    logic        run_sync_pulse, trigger_complete, pointer_valid;
    logic        cyc_end, rst_seen, hit_d, end_d;
    logic [3:0]  cpu_data, ram_bank_select_lines, ext_bank;
    logic [11:0] ext_addr, cyc_addr;
    int          failures, cmp_count, hits, syncs, tcyc, n;
    pa_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_en(phase_en), .cpu_sync(cpu_sync), .cpu_data(cpu_data),
        .ram_bank_select_lines(ram_bank_select_lines), .cpu_test(cpu_test),
        .target_reset(target_reset), .run_sync_pulse(run_sync_pulse),
        .trigger_complete(trigger_complete), .pointer_valid(pointer_valid),
        .ext_addr(ext_addr), .ext_instr(ext_instr), .ext_exec(ext_exec),
        .ext_bank(ext_bank), .ext_pointer(ext_pointer), .irq(irq));
    pa_cpu_model u_cpu (.pclk(pclk), .presetn(presetn),
        .target_reset(target_reset), .phase_en(phase_en),
        .cpu_sync(cpu_sync), .cpu_data(cpu_data),
        .ram_bank_select_lines(ram_bank_select_lines), .cyc_end(cyc_end),
        .cyc_addr(cyc_addr));
    always #10 pclk = ~pclk;
    // ========================================================
    // Monitors, sampled mid-clock where everything is settled
    // Cycle ends seen one clock late, in step with the cycle pulse
    always @(negedge pclk) begin
        if (hit_d && trigger_complete !== 1'b1) hits++;
        if (run_sync_pulse === 1'b1) syncs++;
        if (end_d && cpu_test === 1'b1) tcyc++;
        if (target_reset === 1'b1) rst_seen = 1'b1;
        hit_d = (cyc_end === 1'b1 && cyc_addr === 12'h003);
        end_d = (cyc_end === 1'b1);
    end
    // ========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50) begin
            k++;
            @(posedge pclk);
        end
        if (k >= 50) failures++;
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rv & m, e);
    endtask
    task automatic arm(input logic [31:0] c, input logic [15:0] s,
                       input logic [31:0] cmd);
        apb(1'b1, pa_pkg::ADDR_CTRL, c);
        apb(1'b1, pa_pkg::ADDR_SETUP, {16'h0, s});
        apb(1'b1, pa_pkg::ADDR_CMD, cmd);
        hits = 0;
        syncs = 0;
    endtask
    // Bounded by the watchdog; the partner never stops its cycles
    task automatic cyc(input int c);
        repeat (c) begin
            @(negedge pclk);
            while (cyc_end !== 1'b1) @(negedge pclk);
        end
        repeat (3) @(posedge pclk);
    endtask
    task automatic wait_trig;
        n = 0;
        @(negedge pclk);
        while (trigger_complete !== 1'b1 && n < 3000) begin
            n++;
            @(negedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("compares=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ========================================================
    // Watchdog, far beyond the longest pass-count wait
    initial begin
        #1000000;
        failures++;
        tally_and_finish;
    end
    // ========================================================
    // Tests
    initial begin
        {pclk, presetn, psel, penable, pwrite, rst_seen} = 6'h00;
        {paddr, pwdata} = 40'h0;
        {failures, cmp_count, hits, syncs, tcyc} = 160'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({pready, pslverr}, 32'h2);
        rchk(pa_pkg::ADDR_TRIG_NOW, 32'hFFF, 32'h0);
        rchk(8'h20, 32'hFFFF_FFFF, 32'h0);
        apb(1'b1, pa_pkg::ADDR_IRQ_MASK, 32'h1);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, pa_pkg::ADDR_IRQ_STAT, 32'h0);
            arm(32'h0, i ? 16'hF003 : 16'h1003, i ? 32'h11 : 32'h01);
            wait_trig;
            chk(trigger_complete, 32'h1);
            chk(hits, i ? 32'd15 : 32'd1);
            chk(ext_addr, 32'h003);
            chk({ext_bank, ext_exec, ext_instr}, 32'h83CD3);
            rchk(pa_pkg::ADDR_CAPTURE, 32'hFFFF_FFFF, 32'h83CD3003);
            chk(irq, 32'h1);
            rchk(pa_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1);
            @(posedge pclk);
            chk(irq, 32'h0);
            chk({pointer_valid, ext_pointer}, 32'h12D);
            cyc(6);
            chk(ext_addr, 32'h003);
        end
        chk(rst_seen, 32'h1);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, pa_pkg::ADDR_CMD, i ? 32'h4 : 32'h2);
            rchk(pa_pkg::ADDR_TRIG_NOW, 32'hFFF, i ? 32'h3 : 32'h4);
            wait_trig;
            chk(ext_addr, i ? 32'h3 : 32'h4);
        end
        arm(32'h1, 16'h1003, 32'h1);
        wait_trig;
        chk({ext_instr, ext_addr}, 32'hD4004);
        arm(32'h2, 16'h0003, 32'h1);
        cyc(1);
        syncs = 0;
        cyc(10);
        chk(syncs, 32'h2);
        chk(trigger_complete, 32'h0);
        for (int i = 0; i < 3; i++) begin
            n = int'(ext_addr);
            cyc(1);
            chk(ext_addr, (n == 4) ? 32'h0 : n + 1);
        end
        apb(1'b1, pa_pkg::ADDR_CTRL, 32'h0);
        tcyc = 0;
        apb(1'b1, pa_pkg::ADDR_CMD, 32'h8);
        cyc(4);
        chk({cpu_test, tcyc[3:0]}, 32'h02);
        apb(1'b1, pa_pkg::ADDR_CTRL, 32'h4);
        cyc(3);
        chk(cpu_test, 32'h1);
        apb(1'b1, pa_pkg::ADDR_CTRL, 32'h0);
        @(posedge pclk);
        chk(cpu_test, 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
